// file: shared/lmd_pkg.sv
// laser monitor and dither register bank: shared constants and types
// assumes a 32-bit AHB-Lite bus with one word per register index
package lmd_pkg;
   // register indices; byte address is index times four
   typedef logic [7:0] lmd_idx_t;
   localparam int unsigned IDX_LSB  = 2;
   localparam int unsigned IDX_MSB  = 9;
   localparam lmd_idx_t    IDX_CUR  = 8'h57;
   localparam lmd_idx_t    IDX_TMP  = 8'h58;
   localparam lmd_idx_t    IDX_DE   = 8'h59;
   localparam lmd_idx_t    IDX_DR   = 8'h5A;
   localparam lmd_idx_t    IDX_DF   = 8'h5B;
   localparam lmd_idx_t    IDX_DA   = 8'h5C;
   localparam lmd_idx_t    IDX_WIN  = 8'h60;
   localparam lmd_idx_t    IDX_RES  = 8'h61;
   localparam lmd_idx_t    IDX_IST  = 8'h62;
   localparam lmd_idx_t    IDX_IMSK = 8'h63;

   // snapshot array limits
   localparam int unsigned ARR_MAX_BYTES = 20;
   localparam int unsigned ARR_MAX_WORDS = ARR_MAX_BYTES / 2;

   // dither enable/shape field layout and codes
   localparam int unsigned DE_LSB     = 0;
   localparam int unsigned WF_LSB     = 4;
   localparam logic [1:0]  DE_OFF     = 2'h0;
   localparam logic [1:0]  DE_ANALOG  = 2'h1;
   localparam logic [1:0]  DE_DIGITAL = 2'h2;
   localparam logic [1:0]  DE_BAD     = 2'h3;
   localparam logic [1:0]  WF_SINE    = 2'h0;
   localparam logic [1:0]  WF_TRI     = 2'h1;

   // command result register: status bit and error condition code
   localparam int unsigned RES_XE_BIT  = 0;
   localparam int unsigned RES_ERR_LSB = 4;
   localparam logic [3:0]  ERR_OK      = 4'h0;
   localparam logic [3:0]  ERR_CIP     = 4'h1;
   localparam logic [3:0]  ERR_CII     = 4'h2;
   localparam logic [3:0]  ERR_EXF     = 4'h3;
   localparam logic [3:0]  ERR_VSE     = 4'h4;

   // interrupt status / mask bits
   localparam int unsigned IRQ_W    = 3;
   localparam int unsigned IRQ_SNAP = 0;
   localparam int unsigned IRQ_XE   = 1;
   localparam int unsigned IRQ_DONE = 2;

   // settle time of a pending dither write, least time, rounded up
   localparam int unsigned CLK_PS   = 4000;
   localparam int unsigned PEND_NS  = 1000;
   localparam int unsigned PEND_CYC = (PEND_NS * 1000 + CLK_PS - 1) / CLK_PS;

   typedef struct packed {
      logic [1:0]  mode;
      logic [1:0]  shape;
      logic [15:0] rate;
      logic [15:0] fm;
      logic [15:0] am;
   } lmd_dither_t;

   typedef struct packed {
      logic     valid;
      logic     hi;
      lmd_idx_t idx;
   } lmd_wph_t;
endpackage

// file: hw/lmd_regs.sv
// laser monitor snapshot and dither configuration registers on AHB-Lite
// assumes live measurements arrive from logic on hclk, one 16-bit word per entry
//
// Contract
// - current snapshot read returns byte count and aims window at current array
// - current snapshot read copies all live currents into the window buffer
// - at most twenty array bytes are ever returned
// - current array: cooler, diode 1, diodes 2-4, optical amplifier in order
// - current words are unsigned tenths of a milliampere, passed unchanged
// - temperature snapshot read returns byte count and aims window at temps
// - temperature snapshot read copies all live temperatures into the buffer
// - temperature words are hundredths of a degree, passed unchanged
// - failed snapshot read returns zero, sets error status and a condition
// - analog and digital dither are optional capabilities
// - digital dither is the preferred dither mechanism
// - enable field: 0 off, 1 analog, 2 digital, 3 is an error
// - waveform field: 0 sine, 1 symmetric triangle
// - rate, deviation, depth change only while digital dither is off
// - rate in kHz, deviation in 0.1 GHz, depth in 0.1 percent
`timescale 1ns/1ps
module lmd_regs
   import lmd_pkg::*;
#(
   parameter int unsigned CUR_BYTES = 12,
   parameter int unsigned TMP_BYTES = 8,
   parameter logic [15:0] RATE_MIN  = 16'h000A,
   parameter logic [15:0] RATE_MAX  = 16'h00C8,
   parameter logic [15:0] RATE_RST  = 16'h000A,
   parameter logic [1:0]  MODE_RST  = 2'h0
)(
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic      [31:0]                  hrdata,
   input  wire logic [ARR_MAX_WORDS*16-1:0]  live_cur,
   input  wire logic [ARR_MAX_WORDS*16-1:0]  live_temp,
   input  wire logic                         live_valid,
   output lmd_dither_t                       dither_cfg,
   output logic                              irq
);
   localparam int unsigned CUR_WORDS = CUR_BYTES / 2;
   localparam int unsigned TMP_WORDS = TMP_BYTES / 2;

   initial begin
      if (CUR_BYTES == 0 || CUR_BYTES > ARR_MAX_BYTES || CUR_BYTES % 2 != 0)
         $error("CUR_BYTES must be even and 2..20");
      if (TMP_BYTES == 0 || TMP_BYTES > ARR_MAX_BYTES || TMP_BYTES % 2 != 0)
         $error("TMP_BYTES must be even and 2..20");
      if (RATE_MIN > RATE_MAX || RATE_RST < RATE_MIN || RATE_RST > RATE_MAX)
         $error("dither rate limits inconsistent");
      if (MODE_RST == DE_BAD)
         $error("MODE_RST must not be the invalid mode");
   end

   typedef enum logic [1:0] {WIN_NONE, WIN_CUR, WIN_TMP} lmd_win_t;

   lmd_win_t          win_r;
   logic [3:0]        ptr_r;
   logic [3:0]        cnt_r;
   logic [15:0]       arr_r [ARR_MAX_WORDS];
   lmd_dither_t       dit_r;
   lmd_wph_t          wph_r;
   logic [7:0]        res_r;
   logic [IRQ_W-1:0]  ist_r;
   logic [IRQ_W-1:0]  msk_r;
   logic [8:0]        pend_r;
   logic [31:0]       hrdata_r;

   logic              take, rd, busy, hi;
   lmd_idx_t          a_idx;
   logic [15:0]       rdata_nxt;
   logic [3:0]        rcode, wcode;
   logic              rcmd, wcmd, cur_snap, tmp_snap, win_adv;
   logic              de_we, dr_we, df_we, da_we, msk_we;
   logic [IRQ_W-1:0]  ist_clr, ist_set;
   logic [15:0]       wd;

   // zero-wait slave; errors go to the result register, never to hresp
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;
   assign take      = hsel & htrans[1] & hready;
   assign rd        = take & ~hwrite;
   assign a_idx     = haddr[IDX_MSB:IDX_LSB];
   assign hi        = |haddr[31:IDX_MSB+1];
   assign busy      = pend_r != 9'h000;
   assign wd        = hwdata[15:0];
   assign dither_cfg = dit_r;

   // read decode in the address phase so hrdata can come from a flop
   always_comb begin
      rdata_nxt = 16'h0000;
      rcode     = ERR_OK;
      // bookkeeping registers never touch the result register
      rcmd      = rd & (hi | (a_idx != IDX_RES && a_idx != IDX_IST && a_idx != IDX_IMSK));
      cur_snap  = 1'b0;
      tmp_snap  = 1'b0;
      win_adv   = 1'b0;
      if (rd && hi) begin
         rcode = ERR_CII;
      end else if (rd) begin
         case (a_idx)
            IDX_CUR, IDX_TMP: begin
               if (!live_valid) begin
                  rcode = ERR_EXF;
               end else if (a_idx == IDX_CUR) begin
                  cur_snap  = 1'b1;
                  rdata_nxt = 16'(CUR_BYTES);
               end else begin
                  tmp_snap  = 1'b1;
                  rdata_nxt = 16'(TMP_BYTES);
               end
            end
            IDX_WIN: begin
               // reads past the count return zero and flag an error
               if (win_r != WIN_NONE && ptr_r < cnt_r) begin
                  rdata_nxt = arr_r[ptr_r];
                  win_adv   = 1'b1;
               end else begin
                  rcode = ERR_EXF;
               end
            end
            IDX_DE:   rdata_nxt = {10'h000, dit_r.shape, 2'h0, dit_r.mode};
            IDX_DR:   rdata_nxt = dit_r.rate;
            IDX_DF:   rdata_nxt = dit_r.fm;
            IDX_DA:   rdata_nxt = dit_r.am;
            IDX_RES:  rdata_nxt = {8'h00, res_r};
            IDX_IST:  rdata_nxt = 16'(ist_r);
            IDX_IMSK: rdata_nxt = 16'(msk_r);
            default:  rcode     = ERR_CII;
         endcase
      end
   end

   // write checks in the data phase, against the saved address
   always_comb begin
      wcode   = ERR_OK;
      wcmd    = wph_r.valid & (wph_r.hi | (wph_r.idx != IDX_RES && wph_r.idx != IDX_IST
                                           && wph_r.idx != IDX_IMSK));
      de_we   = 1'b0;
      dr_we   = 1'b0;
      df_we   = 1'b0;
      da_we   = 1'b0;
      msk_we  = 1'b0;
      ist_clr = '0;
      if (wph_r.valid && wph_r.hi) begin
         wcode = ERR_CII;
      end else if (wph_r.valid) begin
         case (wph_r.idx)
            IDX_DE: begin
               if (busy)
                  wcode = ERR_CIP;
               else if (wd[DE_LSB+:2] == DE_BAD || wd[WF_LSB+:2] > WF_TRI)
                  wcode = ERR_EXF;
               else
                  de_we = 1'b1;
            end
            IDX_DR, IDX_DF, IDX_DA: begin
               if (busy)
                  wcode = ERR_CIP;
               else if (dit_r.mode == DE_DIGITAL)
                  wcode = ERR_EXF;
               else if (wph_r.idx == IDX_DR && (wd < RATE_MIN || wd > RATE_MAX))
                  wcode = ERR_EXF;
               else begin
                  dr_we = wph_r.idx == IDX_DR;
                  df_we = wph_r.idx == IDX_DF;
                  da_we = wph_r.idx == IDX_DA;
               end
            end
            IDX_IST:  ist_clr = hwdata[IRQ_W-1:0];
            IDX_IMSK: msk_we  = 1'b1;
            IDX_RES:  wcode   = ERR_OK;
            default:  wcode   = ERR_CII;
         endcase
      end
   end

   // address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wph_r <= '0;
      end else begin
         wph_r.valid <= take & hwrite;
         wph_r.hi    <= hi;
         wph_r.idx   <= a_idx;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_r <= 32'h0000_0000;
      else if (rd)
         hrdata_r <= {16'h0000, rdata_nxt};
   end

   // snapshot buffer: one coherent copy, taken in the read's own cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < ARR_MAX_WORDS; i++)
            arr_r[i] <= 16'h0000;
      end else if (cur_snap) begin
         for (int i = 0; i < ARR_MAX_WORDS; i++)
            arr_r[i] <= live_cur[i*16+:16];
      end else if (tmp_snap) begin
         for (int i = 0; i < ARR_MAX_WORDS; i++)
            arr_r[i] <= live_temp[i*16+:16];
      end
   end

   // window pointer and selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_r <= WIN_NONE;
         ptr_r <= 4'h0;
         cnt_r <= 4'h0;
      end else if (cur_snap) begin
         win_r <= WIN_CUR;
         ptr_r <= 4'h0;
         cnt_r <= 4'(CUR_WORDS);
      end else if (tmp_snap) begin
         win_r <= WIN_TMP;
         ptr_r <= 4'h0;
         cnt_r <= 4'(TMP_WORDS);
      end else if (win_adv) begin
         ptr_r <= ptr_r + 4'h1;
      end
   end

   // dither configuration; digital dither offered, analog passed to pin logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dit_r.mode  <= MODE_RST;
         dit_r.shape <= WF_SINE;
         dit_r.rate  <= RATE_RST;
         dit_r.fm    <= 16'h0000;
         dit_r.am    <= 16'h0000;
      end else begin
         if (de_we) begin
            dit_r.mode  <= wd[DE_LSB+:2];
            dit_r.shape <= wd[WF_LSB+:2];
         end
         if (dr_we)
            dit_r.rate <= wd;
         if (df_we)
            dit_r.fm <= wd;
         if (da_we)
            dit_r.am <= wd;
      end
   end

   // enable and rate writes pend while the laser settles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pend_r <= 9'h000;
      else if (de_we || dr_we)
         pend_r <= 9'(PEND_CYC);
      else if (busy)
         pend_r <= pend_r - 9'h001;
   end

   // result of the latest command; a read decides over an overlapping write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         res_r <= 8'h00;
      else if (rcmd)
         res_r <= {rcode, 3'h0, rcode != ERR_OK};
      else if (wcmd)
         res_r <= {wcode, 3'h0, wcode != ERR_OK};
   end

   // sticky events, write one to clear; a new event beats its clear
   assign ist_set[IRQ_SNAP] = cur_snap | tmp_snap;
   assign ist_set[IRQ_XE]   = (rcmd & rcode != ERR_OK) | (wcmd & wcode != ERR_OK);
   assign ist_set[IRQ_DONE] = pend_r == 9'h001;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ist_r <= '0;
         msk_r <= '0;
      end else begin
         ist_r <= (ist_r & ~ist_clr) | ist_set;
         if (msk_we)
            msk_r <= hwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(ist_r & msk_r);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_cur_rd;
      rd && !hi && a_idx == IDX_CUR;
   endsequence
   sequence s_tmp_rd;
      rd && !hi && a_idx == IDX_TMP;
   endsequence
   sequence s_dw(lmd_idx_t ix);
      wph_r.valid && !wph_r.hi && wph_r.idx == ix && !busy;
   endsequence

   a_cur_count: assert property (s_cur_rd ##0 live_valid |=>
      hrdata == 32'(CUR_BYTES) && win_r == WIN_CUR && ptr_r == 4'h0)
      else $error("current snapshot count or window wrong");
   a_cur_copy: assert property (s_cur_rd ##0 live_valid |=>
      arr_r[0] == $past(live_cur[15:0]) && arr_r[1] == $past(live_cur[31:16]))
      else $error("current snapshot not copied");
   a_cur_tail: assert property (s_cur_rd ##0 live_valid |=>
      arr_r[5] == $past(live_cur[95:80]))
      else $error("amplifier current not in array word 5");
   a_win_bound: assert property (ptr_r <= cnt_r && cnt_r <= 4'(ARR_MAX_WORDS))
      else $error("window pointer beyond array");
   a_win_over: assert property (rd && !hi && a_idx == IDX_WIN && ptr_r == cnt_r
      |=> hrdata == 32'h0000_0000 && res_r[RES_XE_BIT])
      else $error("read past array end not refused");
   a_tmp_count: assert property (s_tmp_rd ##0 live_valid |=>
      hrdata == 32'(TMP_BYTES) && win_r == WIN_TMP ##0 arr_r[0] == $past(live_temp[15:0]))
      else $error("temperature snapshot wrong");
   a_snap_fail: assert property ((s_cur_rd or s_tmp_rd) ##0 !live_valid |=>
      hrdata == 32'h0000_0000 && res_r == {ERR_EXF, 3'h0, 1'b1} && ist_r[IRQ_XE])
      else $error("failed snapshot read not reported");
   a_bad_mode: assert property (s_dw(IDX_DE) ##0 wd[DE_LSB+:2] == DE_BAD |=>
      $stable(dit_r.mode) && res_r[RES_XE_BIT])
      else $error("invalid dither mode accepted");
   a_rate_lock: assert property (s_dw(IDX_DR) ##0 dit_r.mode == DE_DIGITAL |=>
      $stable(dit_r.rate) && res_r[RES_ERR_LSB+:4] == ERR_EXF)
      else $error("rate changed while digital dither on");
   // the counter is loaded at the write's edge, so eight cycles later it is seven lower
   a_pend_len: assert property (de_we |=> busy [*8] ##0 pend_r == 9'(PEND_CYC - 7))
      else $error("pending window length wrong");
endmodule

// file: sim/lmd_meas_src.sv
// live measurement source facing the register bank's monitor inputs
// assumes refresh is a one-cycle request from the bench, sampled on hclk
`timescale 1ns/1ps
module lmd_meas_src
   import lmd_pkg::*;
(
   input  wire logic                        hclk,
   input  wire logic                        refresh,
   input  wire logic                        usable,
   output logic      [ARR_MAX_WORDS*16-1:0] live_cur,
   output logic      [ARR_MAX_WORDS*16-1:0] live_temp,
   output logic                             live_valid
);
   int seed = 32'hd409bc3e;

   initial live_cur = '0;
   initial live_temp = '0;

   // new readings only on request, so the bench knows what was live at a snapshot
   always @(posedge hclk) begin
      if (refresh) begin
         for (int i = 0; i < ARR_MAX_WORDS; i++) begin
            live_cur[16*i +: 16]  <= 16'($random(seed));
            live_temp[16*i +: 16] <= 16'($random(seed));
         end
      end
   end

   // the bench drops usable to make a snapshot fail
   assign live_valid = usable;
endmodule

// file: sim/laser_monitor_dither_regs_tb.sv
// self-checking bench for the monitor snapshot and dither register bank
// assumes a zero-wait AHB-Lite slave whose hreadyout feeds back as hready
`timescale 1ns/1ps
module laser_monitor_dither_regs_tb;
   import lmd_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        refresh = 1'b0;
   logic        usable = 1'b1;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout, hresp, irq, live_valid;
   logic [31:0] hrdata, r, de_exp, dr_exp, v;
   logic [159:0] live_cur, live_temp, snap;
   lmd_dither_t dither_cfg;
   logic [15:0] rates [4] = '{16'h0009, 16'h000A, 16'h00C8, 16'h00C9};
   logic        ok;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   int          seed = 32'hd409bc3e;

   // accepted rate band as set on the instance defaults
   localparam logic [15:0] RATE_LIM_LO = 16'h000A;
   localparam logic [15:0] RATE_LIM_HI = 16'h00C8;

   // free-running bus clock, 4 ns period
   always #2 hclk = ~hclk;

   lmd_regs lmd_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .live_cur(live_cur),
      .live_temp(live_temp), .live_valid(live_valid), .dither_cfg(dither_cfg), .irq(irq));

   lmd_meas_src lmd_meas_src_inst (.hclk(hclk), .refresh(refresh), .usable(usable),
      .live_cur(live_cur), .live_temp(live_temp), .live_valid(live_valid));

   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // a hung handshake must not stall the run forever
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask

   function automatic logic [31:0] adr(input lmd_idx_t i);
      return {22'h0, i, 2'h0};
   endfunction

   function automatic logic [31:0] res(input logic [3:0] c);
      return {24'h0, c, 3'h0, c != ERR_OK};
   endfunction

   // single transfer: address phase, then data phase, each held until hready
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready_ok() == 1'b0);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready_ok() == 1'b0);
      q = hrdata;
   endtask

   function automatic logic hready_ok();
      return hreadyout === 1'b1;
   endfunction

   task automatic wr(input lmd_idx_t i, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, adr(i), d, q);
   endtask

   task automatic rd(input lmd_idx_t i, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, adr(i), 32'h0, q);
      chk(q, e);
   endtask

   // ask the source for new readings and let them land before sampling
   task automatic fresh;
      @(posedge hclk);
      refresh <= 1'b1;
      @(posedge hclk);
      refresh <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(IDX_DE, 32'h0);
      rd(IDX_DR, 32'h000A);
      rd(IDX_DF, 32'h0);
      rd(IDX_DA, 32'h0);
      rd(IDX_IMSK, 32'h0);
      $display("test reset values done");
      // readings change after each snapshot, so old values prove the copy
      for (int k = 0; k < 2; k++) begin
         fresh();
         snap = (k == 1) ? live_temp : live_cur;
         rd((k == 1) ? IDX_TMP : IDX_CUR, (k == 1) ? 32'h8 : 32'hC);
         fresh();
         for (int i = 0; i < ((k == 1) ? 4 : 6); i++)
            rd(IDX_WIN, {16'h0, snap[16*i +: 16]});
         rd(IDX_WIN, 32'h0);
         rd(IDX_RES, res(ERR_EXF));
      end
      usable <= 1'b0;
      rd(IDX_CUR, 32'h0);
      bus(1'b0, adr(IDX_RES), 32'h0, r);
      chk(r & 32'h1, 32'h1);
      usable <= 1'b1;
      $display("test snapshots done");
      wr(IDX_IMSK, 32'h2);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_IMSK, 32'h0);
      @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_IST, 32'h7);
      rd(IDX_IST, 32'h0);
      $display("test interrupt done");
      // every enable code, code 3 refused and leaving the register alone
      de_exp = 32'h0;
      for (int k = 0; k < 4; k++) begin
         wr(IDX_DE, {26'h0, WF_TRI, 2'h0, 2'(k)});
         repeat (260) @(posedge hclk);
         if (k != 3)
            de_exp = {26'h0, WF_TRI, 2'h0, 2'(k)};
         rd(IDX_RES, res((k == 3) ? ERR_EXF : ERR_OK));
         rd(IDX_DE, de_exp);
         chk({30'h0, dither_cfg.mode}, {30'h0, de_exp[1:0]});
      end
      wr(IDX_DF, 32'h5);
      rd(IDX_RES, res(ERR_EXF));
      rd(IDX_DF, 32'h0);
      wr(IDX_DR, 32'h0014);
      rd(IDX_RES, res(ERR_EXF));
      rd(IDX_DR, 32'h000A);
      wr(IDX_DE, 32'h0);
      repeat (260) @(posedge hclk);
      $display("test enable codes done");
      // rate limits on both sides of the accepted band
      dr_exp = 32'h000A;
      for (int i = 0; i < 4; i++) begin
         ok = rates[i] >= RATE_LIM_LO && rates[i] <= RATE_LIM_HI;
         wr(IDX_DR, {16'h0, rates[i]});
         repeat (260) @(posedge hclk);
         if (ok)
            dr_exp = {16'h0, rates[i]};
         rd(IDX_RES, res(ok ? ERR_OK : ERR_EXF));
         rd(IDX_DR, dr_exp);
      end
      v = {16'h0, 16'($random(seed))};
      wr(IDX_DF, v);
      rd(IDX_DF, v);
      chk({16'h0, dither_cfg.fm}, v);
      wr(IDX_DA, v ^ 32'h5A5A);
      rd(IDX_DA, v ^ 32'h5A5A);
      // a dither write while the enable write still settles is refused
      wr(IDX_DE, 32'h0);
      wr(IDX_DA, 32'h1);
      rd(IDX_RES, res(ERR_CIP));
      rd(IDX_DA, v ^ 32'h5A5A);
      // clear older events so only this settle can raise the done bit
      wr(IDX_IST, 32'h7);
      repeat (260) @(posedge hclk);
      bus(1'b0, adr(IDX_IST), 32'h0, r);
      chk(r & 32'h4, 32'h4);
      $display("test rate and pending done");
      bus(1'b0, 32'h400, 32'h0, r);
      chk(r, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      rd(IDX_RES, res(ERR_CII));
      wr(IDX_CUR, 32'h1);
      rd(IDX_RES, res(ERR_CII));
      $display("test refusals done");
      end_of_test();
   end
endmodule
